// ### hw/fpfre_pkg.sv
// Purpose: Shared constants for the floating-point format, rounding and exception block
// Assumes: One 20 MHz clock, synchronous active-high reset
// Notes:   Overview list below is kept short on purpose
//
// Overview of operation
// - Single: sign, 8-bit exponent bias 127, 23-bit fraction
// - Double: sign, 11-bit exponent bias 1023, 52-bit fraction
// - Classify NaN, infinity, denormal, zero, normal by fields
// - Fraction MSB 1 signaling, 0 quiet
// - Signaling NaN, invalid trap off: quiet NaN result
// - Signaling NaN, invalid trap on: trap, keep destination
// - Quiet NaN only: quiet NaN, never an exception
// - Generated quiet NaN uses the fixed patterns
// - Denormal flush fixed on; flush sources and results
// - Sixteen 32-bit registers, even/odd pairs as doubles
// - Precision and transfer-size bits select pair views
// - 32-bit CPU transfer register, feeds integer conversion
// - One rounding per operation, fused op included
// - Rounding field: 00 nearest, 01 toward zero
// - Nearest: ties to even, overflow to infinity
// - Toward zero: truncate, clamp to largest finite
// - Cause set or cleared per op; flags sticky
// - Error cause never set; five flags and enables
// - Trap when enabled and event possible
// - One common exception; destination left unchanged
// - Untrapped: invalid quiet NaN, divide signed infinity
// - Untrapped overflow, underflow, inexact default results

package fpfre_pkg;

	// ------------------------------------------------------------
	// Number formats
	// ------------------------------------------------------------
	localparam int SP_EXP_W  = 8;
	localparam int SP_FRAC_W = 23;
	localparam int DP_EXP_W  = 11;
	localparam int DP_FRAC_W = 52;
	localparam int SP_BIAS   = 127;
	localparam int DP_BIAS   = 1023;
	localparam int MANT_W    = 55;   // 1.f with 52 fraction bits, round, sticky
	localparam int EXP_IN_W  = 14;   // Signed biased exponent from the datapath

	localparam logic signed [EXP_IN_W-1:0] SP_EXP_ONES = 14'sh00ff;
	localparam logic signed [EXP_IN_W-1:0] DP_EXP_ONES = 14'sh07ff;

	localparam logic [31:0] SP_QUIET_NAN = 32'h7fbfffff;
	localparam logic [63:0] DP_QUIET_NAN = 64'h7ff7ffffffffffff;
	localparam logic [30:0] SP_INF  = 31'h7f800000;
	localparam logic [62:0] DP_INF  = 63'h7ff0000000000000;
	localparam logic [30:0] SP_MAXN = 31'h7f7fffff;
	localparam logic [62:0] DP_MAXN = 63'h7fefffffffffffff;

	// ------------------------------------------------------------
	// Status/control register layout
	// ------------------------------------------------------------
	localparam int RM_LSB    = 0;
	localparam int FLAG_LSB  = 2;
	localparam int EN_LSB    = 7;
	localparam int CAUSE_LSB = 12;
	localparam int DN_BIT    = 18;
	localparam int PR_BIT    = 19;
	localparam int SZ_BIT    = 20;
	localparam logic [31:0] FP_STATUS_CONTROL_RESET = 32'h00040001;
	localparam logic [31:0] FP_STATUS_CONTROL_WMASK = 32'h0019ffff;

	// Event index inside flag/enable/cause groups
	localparam int EV_I = 0;
	localparam int EV_U = 1;
	localparam int EV_O = 2;
	localparam int EV_Z = 3;
	localparam int EV_V = 4;
	localparam int EV_E = 5;

	localparam logic [1:0] RM_NEAREST = 2'h0;
	localparam logic [1:0] RM_ZERO    = 2'h1;
	localparam int         RF_DEPTH   = 16;

	typedef enum logic [1:0] {OP_ARITH, OP_MOVE, OP_DIVIDE, OP_FUSED} fpfre_op_e;
	typedef enum logic [2:0] {CLS_ZERO, CLS_DENORM, CLS_NORMAL, CLS_INF, CLS_QUIET_NAN, CLS_SIGNALING_NAN}
		fpfre_cls_e;

endpackage

// ### hw/fpfre_fpu_support.sv
// Purpose: Result rounding, NaN/denormal handling, exception bookkeeping, register files
// Assumes: Datapath hands an unrounded, normalised result in the issue cycle
// Notes:   Result is written, or the exception raised, one cycle after issue
`timescale 1ns/1ps

module fpfre_fpu_support (
	input  wire logic                                 clock_i,
	input  wire logic                                 rst_i,
	// Operation issue
	input  wire logic                                 op_valid_i,
	input  wire fpfre_pkg::fpfre_op_e                 op_kind_i,
	input  wire logic [3:0]                           op_dest_i,
	input  wire logic [63:0]                          src_a_i,
	input  wire logic [63:0]                          src_b_i,
	input  wire logic                                 res_sign_i,
	input  wire logic signed [fpfre_pkg::EXP_IN_W-1:0] res_exp_i,
	input  wire logic [fpfre_pkg::MANT_W-1:0]         res_mant_i,
	input  wire logic                                 res_zero_i,
	input  wire logic                                 invalid_i,
	input  wire logic                                 div_zero_i,
	input  wire logic                                 may_ovf_i,
	input  wire logic                                 may_unf_i,
	input  wire logic                                 may_inx_i,
	output logic                                      flush_a_o,
	output logic                                      flush_b_o,
	// Memory load into the register file
	input  wire logic                                 ld_valid_i,
	input  wire logic [3:0]                           ld_idx_i,
	input  wire logic [63:0]                          ld_data_i,
	// Register read port
	input  wire logic [3:0]                           rd_idx_i,
	input  wire logic                                 rd_pair_i,
	output logic [63:0]                               rd_data_o,
	// System register access
	input  wire logic                                 scr_wr_i,
	input  wire logic [31:0]                          scr_wdata_i,
	output logic [31:0]                               scr_o,
	input  wire logic                                 xfer_wr_i,
	input  wire logic [31:0]                          xfer_wdata_i,
	output logic [31:0]                               xfer_o,
	// Common exception request to the CPU
	output logic                                      fpe_req_o
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// Operand class from exponent and fraction fields
	function automatic fpfre_pkg::fpfre_cls_e classify(input logic [63:0] v, input logic dbl);
		logic e_one;
		logic e_zero;
		logic f_zero;
		logic f_msb;
		if (dbl) begin
			e_one  = &v[fpfre_pkg::DP_FRAC_W +: fpfre_pkg::DP_EXP_W];
			e_zero = ~|v[fpfre_pkg::DP_FRAC_W +: fpfre_pkg::DP_EXP_W];
			f_zero = ~|v[fpfre_pkg::DP_FRAC_W-1:0];
			f_msb  = v[fpfre_pkg::DP_FRAC_W-1];
		end else begin
			e_one  = &v[fpfre_pkg::SP_FRAC_W +: fpfre_pkg::SP_EXP_W];
			e_zero = ~|v[fpfre_pkg::SP_FRAC_W +: fpfre_pkg::SP_EXP_W];
			f_zero = ~|v[fpfre_pkg::SP_FRAC_W-1:0];
			f_msb  = v[fpfre_pkg::SP_FRAC_W-1];
		end
		if (e_one && !f_zero) begin
			classify = f_msb ? fpfre_pkg::CLS_SIGNALING_NAN : fpfre_pkg::CLS_QUIET_NAN;
		end else if (e_one) begin
			classify = fpfre_pkg::CLS_INF;
		end else if (e_zero) begin
			classify = f_zero ? fpfre_pkg::CLS_ZERO : fpfre_pkg::CLS_DENORM;
		end else begin
			classify = fpfre_pkg::CLS_NORMAL;
		end
	endfunction

	// Fixed value with sign, single results sit in the low word
	function automatic logic [63:0] fixed_val(input logic s, input logic dbl,
	                                          input logic [62:0] dv, input logic [30:0] sv);
		fixed_val = dbl ? {s, dv} : {32'h0, s, sv};
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [31:0] fregs_r [fpfre_pkg::RF_DEPTH];
	logic [31:0] scr_r;
	logic [31:0] xfer_r;
	logic        wb_pend_r;
	logic        wb_trap_r;
	logic        wb_dbl_r;
	logic [3:0]  wb_idx_r;
	logic [63:0] wb_data_r;
	logic [5:0]  wb_cause_r;

	logic [1:0]  rmode;
	logic        pr_sel;
	logic        sz_sel;
	logic [4:0]  trap_en;
	logic        op_dbl;
	logic        is_move;
	fpfre_pkg::fpfre_cls_e cls_a;
	fpfre_pkg::fpfre_cls_e cls_b;

	assign rmode   = scr_r[fpfre_pkg::RM_LSB +: 2];
	assign pr_sel  = scr_r[fpfre_pkg::PR_BIT];
	assign sz_sel  = scr_r[fpfre_pkg::SZ_BIT];
	assign trap_en = scr_r[fpfre_pkg::EN_LSB +: 5];
	assign is_move = (op_kind_i == fpfre_pkg::OP_MOVE);
	assign op_dbl  = is_move ? sz_sel : pr_sel;
	assign cls_a   = classify(src_a_i, op_dbl);
	assign cls_b   = classify(src_b_i, op_dbl);

	// Datapath must take denormal sources as zero; moves keep them
	assign flush_a_o = op_valid_i && !is_move && (cls_a == fpfre_pkg::CLS_DENORM);
	assign flush_b_o = op_valid_i && !is_move && (cls_b == fpfre_pkg::CLS_DENORM);

	// ------------------------------------------------------------
	// Rounding of the unrounded result
	// ------------------------------------------------------------
	logic [52:0] sig;
	logic        rbit;
	logic        stk;
	logic        inc;
	logic [53:0] sig_r;
	logic        carry;
	logic signed [fpfre_pkg::EXP_IN_W-1:0] exp_r;
	logic        ovf;
	logic        unf;
	logic        inx;
	logic [63:0] rounded;

	// Single precision keeps 24 bits, double 53; one rounding per op
	always_comb begin
		if (op_dbl) begin
			sig  = res_mant_i[fpfre_pkg::MANT_W-1 -: fpfre_pkg::DP_FRAC_W+1];
			rbit = res_mant_i[1];
			stk  = res_mant_i[0];
		end else begin
			sig  = {29'h0, res_mant_i[fpfre_pkg::MANT_W-1 -: fpfre_pkg::SP_FRAC_W+1]};
			rbit = res_mant_i[fpfre_pkg::MANT_W-fpfre_pkg::SP_FRAC_W-2];
			stk  = |res_mant_i[fpfre_pkg::MANT_W-fpfre_pkg::SP_FRAC_W-3:0];
		end
		inc   = (rmode == fpfre_pkg::RM_NEAREST) && rbit && (stk || sig[0]);
		sig_r = {1'b0, sig} + {53'h0, inc};
		carry = op_dbl ? sig_r[53] : sig_r[24];
		exp_r = res_exp_i + $signed({13'h0, carry});
		ovf   = op_dbl ? (exp_r >= fpfre_pkg::DP_EXP_ONES) : (exp_r >= fpfre_pkg::SP_EXP_ONES);
		unf   = (exp_r < 14'sh0001);
		inx   = rbit || stk || ovf || unf;
		if (op_dbl) begin
			rounded = {res_sign_i, exp_r[10:0], carry ? 52'h0 : sig_r[51:0]};
		end else begin
			rounded = {32'h0, res_sign_i, exp_r[7:0], carry ? 23'h0 : sig_r[22:0]};
		end
	end

	// ------------------------------------------------------------
	// Event detection and default result selection
	// ------------------------------------------------------------
	logic        signaling_nan_in;
	logic        quiet_nan_in;
	logic        ev_v;
	logic        ev_z;
	logic        ev_o;
	logic        ev_u;
	logic        ev_i;
	logic        trap;
	logic [5:0]  cause;
	logic [63:0] result;

	always_comb begin
		signaling_nan_in = !is_move && (cls_a == fpfre_pkg::CLS_SIGNALING_NAN || cls_b == fpfre_pkg::CLS_SIGNALING_NAN);
		quiet_nan_in = !is_move && !signaling_nan_in
		          && (cls_a == fpfre_pkg::CLS_QUIET_NAN || cls_b == fpfre_pkg::CLS_QUIET_NAN);
		ev_v = !is_move && !quiet_nan_in && (signaling_nan_in || invalid_i);
		ev_z = (op_kind_i == fpfre_pkg::OP_DIVIDE) && !ev_v && !quiet_nan_in && div_zero_i;
		ev_o = !is_move && !ev_v && !quiet_nan_in && !ev_z && !res_zero_i && ovf;
		ev_u = !is_move && !ev_v && !quiet_nan_in && !ev_z && !res_zero_i && unf;
		ev_i = !is_move && !ev_v && !quiet_nan_in && !ev_z && !res_zero_i && inx;
		// Enabled and possible starts handling; quiet NaN never traps
		trap = !is_move && !quiet_nan_in && ((trap_en[fpfre_pkg::EV_V] && ev_v)
		       || (trap_en[fpfre_pkg::EV_Z] && ev_z) || (trap_en[fpfre_pkg::EV_O] && may_ovf_i)
		       || (trap_en[fpfre_pkg::EV_U] && may_unf_i)
		       || (trap_en[fpfre_pkg::EV_I] && may_inx_i));
		cause = {1'b0, ev_v, ev_z, ev_o, ev_u, ev_i};
		if (is_move) begin
			result = src_a_i;
		end else if (ev_v || quiet_nan_in) begin
			result = op_dbl ? fpfre_pkg::DP_QUIET_NAN : {32'h0, fpfre_pkg::SP_QUIET_NAN};
		end else if (ev_z) begin
			result = fixed_val(res_sign_i, op_dbl, fpfre_pkg::DP_INF, fpfre_pkg::SP_INF);
		end else if (res_zero_i || ev_u) begin
			result = fixed_val(res_sign_i, op_dbl, 63'h0, 31'h0);
		end else if (ev_o && rmode == fpfre_pkg::RM_NEAREST) begin
			result = fixed_val(res_sign_i, op_dbl, fpfre_pkg::DP_INF, fpfre_pkg::SP_INF);
		end else if (ev_o) begin
			result = fixed_val(res_sign_i, op_dbl, fpfre_pkg::DP_MAXN, fpfre_pkg::SP_MAXN);
		end else begin
			result = rounded;
		end
	end

	// ------------------------------------------------------------
	// Write-back stage
	// ------------------------------------------------------------

	// One stage so trap and write land in the same cycle
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			wb_pend_r  <= 1'b0;
			wb_trap_r  <= 1'b0;
			wb_dbl_r   <= 1'b0;
			wb_idx_r   <= 4'h0;
			wb_data_r  <= 64'h0;
			wb_cause_r <= 6'h0;
		end else begin
			wb_pend_r  <= op_valid_i;
			wb_trap_r  <= op_valid_i && trap;
			wb_dbl_r   <= op_dbl;
			wb_idx_r   <= op_dest_i;
			wb_data_r  <= result;
			wb_cause_r <= is_move ? 6'h0 : cause;
		end
	end

	logic wb_we;
	logic upd_scr;
	assign wb_we     = wb_pend_r && !wb_trap_r;
	assign upd_scr   = wb_pend_r;
	assign fpe_req_o = wb_trap_r;

	// ------------------------------------------------------------
	// Register file, pair view even word high
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < fpfre_pkg::RF_DEPTH; gi++) begin : g_freg
			// Sized copy of the loop index so its bits can be selected
			localparam logic [3:0] IDX = 4'(gi);
			// Arithmetic write-back wins over a same-cycle memory load
			always_ff @(posedge clock_i) begin
				if (rst_i) begin
					fregs_r[gi] <= 32'h0;
				end else if (wb_we && wb_dbl_r && wb_idx_r[3:1] == IDX[3:1]) begin
					fregs_r[gi] <= IDX[0] ? wb_data_r[31:0] : wb_data_r[63:32];
				end else if (wb_we && !wb_dbl_r && wb_idx_r == IDX) begin
					fregs_r[gi] <= wb_data_r[31:0];
				end else if (ld_valid_i && sz_sel && ld_idx_i[3:1] == IDX[3:1]) begin
					fregs_r[gi] <= IDX[0] ? ld_data_i[31:0] : ld_data_i[63:32];
				end else if (ld_valid_i && !sz_sel && ld_idx_i == IDX) begin
					fregs_r[gi] <= ld_data_i[31:0];
				end
			end
		end
	endgenerate

	// Registered read, single view in the low word
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rd_data_o <= 64'h0;
		end else if (rd_pair_i) begin
			rd_data_o <= {fregs_r[{rd_idx_i[3:1], 1'b0}], fregs_r[{rd_idx_i[3:1], 1'b1}]};
		end else begin
			rd_data_o <= {32'h0, fregs_r[rd_idx_i]};
		end
	end

	// ------------------------------------------------------------
	// System registers
	// ------------------------------------------------------------

	// Hardware flag sets are ORed in so a software clear cannot lose them
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			scr_r <= fpfre_pkg::FP_STATUS_CONTROL_RESET;
		end else begin
			if (scr_wr_i) begin
				scr_r <= (scr_wdata_i & fpfre_pkg::FP_STATUS_CONTROL_WMASK) | fpfre_pkg::FP_STATUS_CONTROL_RESET
				         & ~fpfre_pkg::FP_STATUS_CONTROL_WMASK;
			end
			if (upd_scr) begin
				scr_r[fpfre_pkg::CAUSE_LSB +: 6] <= wb_cause_r;
				scr_r[fpfre_pkg::FLAG_LSB +: 5] <= wb_cause_r[4:0]
					| (scr_wr_i ? scr_wdata_i[fpfre_pkg::FLAG_LSB +: 5]
					            : scr_r[fpfre_pkg::FLAG_LSB +: 5]);
			end
		end
	end
	assign scr_o = scr_r;

	// CPU transfer register, also the integer conversion source
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			xfer_r <= 32'h0;
		end else if (xfer_wr_i) begin
			xfer_r <= xfer_wdata_i;
		end
	end
	assign xfer_o = xfer_r;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	property p_signaling_nan_quiet;
		op_valid_i && !is_move && signaling_nan_in && !trap_en[fpfre_pkg::EV_V] && !trap && !op_dbl
		|=> wb_we && wb_data_r == {32'h0, fpfre_pkg::SP_QUIET_NAN};
	endproperty
	a_signaling_nan_quiet: assert property (p_signaling_nan_quiet) else $error("signaling_nan did not yield quiet_nan");

	property p_signaling_nan_trap;
		op_valid_i && signaling_nan_in && trap_en[fpfre_pkg::EV_V] |=> fpe_req_o && !wb_we;
	endproperty
	a_signaling_nan_trap: assert property (p_signaling_nan_trap) else $error("signaling_nan trap missing");

	property p_quiet_nan_notrap;
		op_valid_i && quiet_nan_in |=> !fpe_req_o
		##1 !scr_r[fpfre_pkg::CAUSE_LSB + fpfre_pkg::EV_V]; // Cause lands a cycle later
	endproperty
	a_quiet_nan_notrap: assert property (p_quiet_nan_notrap) else $error("quiet_nan raised exception");

	property p_dn_fixed;
		scr_r[fpfre_pkg::DN_BIT] && !scr_r[fpfre_pkg::CAUSE_LSB + fpfre_pkg::EV_E];
	endproperty
	a_dn_fixed: assert property (p_dn_fixed) else $error("flush bit or error cause wrong");

	property p_flags_sticky;
		!scr_wr_i |=> (scr_r[fpfre_pkg::FLAG_LSB +: 5] & $past(scr_r[fpfre_pkg::FLAG_LSB +: 5]))
		              == $past(scr_r[fpfre_pkg::FLAG_LSB +: 5]);
	endproperty
	a_flags_sticky: assert property (p_flags_sticky) else $error("flag lost");

	property p_ovf_nearest;
		op_valid_i && !trap && ev_o && rmode == fpfre_pkg::RM_NEAREST && !op_dbl
		|=> wb_data_r[30:0] == fpfre_pkg::SP_INF;
	endproperty
	a_ovf_nearest: assert property (p_ovf_nearest) else $error("overflow not infinity");

	property p_ovf_zero;
		op_valid_i && !trap && ev_o && rmode == fpfre_pkg::RM_ZERO
		|=> (wb_dbl_r ? wb_data_r[62:0] == fpfre_pkg::DP_MAXN
		              : wb_data_r[30:0] == fpfre_pkg::SP_MAXN);
	endproperty
	a_ovf_zero: assert property (p_ovf_zero) else $error("overflow not clamped");

	property p_pulse;
		fpe_req_o |-> $past(op_valid_i) && $past(trap_en != 5'h00) && !wb_we
		##1 (!fpe_req_o || $past(op_valid_i));
	endproperty
	a_pulse: assert property (p_pulse) else $error("exception request not tied to op");

	property p_trap_keeps;
		wb_trap_r && !ld_valid_i |=> fregs_r[$past(wb_idx_r)] == $past(fregs_r[wb_idx_r]);
	endproperty
	a_trap_keeps: assert property (p_trap_keeps) else $error("trap changed register");

	c_trap:  cover property (op_valid_i && trap ##1 fpe_req_o);
	c_ovf:   cover property (op_valid_i && ev_o && !trap);
	c_tie:   cover property (op_valid_i && rbit && !stk && !sig[0] && !is_move);
	c_pairw: cover property (wb_we && wb_dbl_r);

endmodule

// ### sim/fpfre_cpu_model.sv
// Purpose: Host CPU side that takes the common floating-point exception
// Assumes: Exception request is a one-cycle pulse on the CPU clock
// Notes:   A stretched request counts once per cycle, so the bench sees it
`timescale 1ns/1ps

module fpfre_cpu_model (
	input  wire logic       clock_i,
	input  wire logic       rst_i,
	input  wire logic       fpe_req_i,
	output logic [7:0]      trap_cnt_o,
	output logic            wb_block_o
);
	// ------------------------------------------------------------
	// Exception entry
	// ------------------------------------------------------------
	// Write-back is suppressed in the request cycle itself
	assign wb_block_o = fpe_req_i;

	// Every sampled request is one entry into the exception sequence
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			trap_cnt_o <= 8'h00;
		end else if (fpe_req_i) begin
			trap_cnt_o <= trap_cnt_o + 8'h01;
		end
	end
endmodule

// ### sim/tb_top.sv
// Purpose: Self-checking bench for rounding, NaN, flush and exception bookkeeping
// Assumes: Results land one cycle after issue; reads have one cycle latency
// Notes:   Expected values come from a small integer model kept in the bench
`timescale 1ns/1ps

module tb_top;
	// ------------------------------------------------------------
	// Signals and model state
	// ------------------------------------------------------------
	logic                 clock_i = 1'b0;
	logic                 rst_i = 1'b1;
	logic                 op_valid_i, res_sign_i, res_zero_i, invalid_i, div_zero_i;
	logic                 may_ovf_i, may_unf_i, may_inx_i, ld_valid_i, rd_pair_i;
	logic                 scr_wr_i, xfer_wr_i, flush_a_o, flush_b_o, fpe_req_o, s;
	fpfre_pkg::fpfre_op_e op_kind_i;
	logic [3:0]           op_dest_i, ld_idx_i, rd_idx_i;
	logic [63:0]          src_a_i, src_b_i, ld_data_i, rd_data_o;
	logic signed [13:0]   res_exp_i;
	logic [54:0]          res_mant_i, m;
	logic [31:0]          scr_wdata_i, xfer_wdata_i, scr_o, xfer_o, scr_m, w, r;
	logic [31:0]          regs_m [16];
	logic [7:0]           cnt;
	logic [4:0]           ev;
	logic [51:0]          f;
	int                   fails, checked;
	localparam logic [54:0] mant_one = 55'h40000000000000;
	// Rounding cases: tie odd, tie even, truncate, overflow both modes, underflow, exact
	logic [1:0]  rmt [7] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h0};
	int          ext [7] = '{127, 127, 130, 254, 255, 0, 100};
	logic [54:0] mt [7] = '{{24'hc00001, 31'h40000000}, {24'h800002, 31'h40000000},
		{24'hffffff, 31'h40000000}, {24'hffffff, 31'h40000000}, {24'h800000, 31'h00000000},
		{24'h800000, 31'h00000000}, {24'h900000, 31'h00000000}};

	always #25 clock_i = ~clock_i;

	fpfre_fpu_support fpfre_fpu_support_i (
		.clock_i(clock_i), .rst_i(rst_i), .op_valid_i(op_valid_i), .op_kind_i(op_kind_i),
		.op_dest_i(op_dest_i), .src_a_i(src_a_i), .src_b_i(src_b_i), .res_sign_i(res_sign_i),
		.res_exp_i(res_exp_i), .res_mant_i(res_mant_i), .res_zero_i(res_zero_i),
		.invalid_i(invalid_i), .div_zero_i(div_zero_i), .may_ovf_i(may_ovf_i),
		.may_unf_i(may_unf_i), .may_inx_i(may_inx_i), .flush_a_o(flush_a_o),
		.flush_b_o(flush_b_o), .ld_valid_i(ld_valid_i), .ld_idx_i(ld_idx_i),
		.ld_data_i(ld_data_i), .rd_idx_i(rd_idx_i), .rd_pair_i(rd_pair_i), .rd_data_o(rd_data_o),
		.scr_wr_i(scr_wr_i), .scr_wdata_i(scr_wdata_i), .scr_o(scr_o), .xfer_wr_i(xfer_wr_i),
		.xfer_wdata_i(xfer_wdata_i), .xfer_o(xfer_o), .fpe_req_o(fpe_req_o));

	fpfre_cpu_model fpfre_cpu_model_i (.clock_i(clock_i), .rst_i(rst_i), .fpe_req_i(fpe_req_o),
		.trap_cnt_o(cnt), .wb_block_o());

	// ------------------------------------------------------------
	// Compare, report and model helpers
	// ------------------------------------------------------------
	task automatic chk_val(input logic [63:0] g, input logic [63:0] e);
		checked++;
		if (g !== e) begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic chk_ctl(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic summarize;
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Single rounding; event bits in flag order {V,Z,O,U,I}
	function automatic logic [31:0] sp_rnd(input logic sg, input int e, input logic [54:0] mm,
		input logic rz, output logic [4:0] evo);
		logic [24:0] sig;
		sig = {1'b0, mm[54:31]};
		if (!rz && mm[30] && (mm[31] || mm[29:0] != 30'h0)) begin
			sig = sig + 25'h1;
		end
		if (sig[24]) begin
			e = e + 1;
			sig = sig >> 1;
		end
		evo = {4'h0, mm[30] || mm[29:0] != 30'h0};
		if (e >= 255) begin
			evo = evo | 5'h05;
			return rz ? {sg, fpfre_pkg::SP_MAXN} : {sg, fpfre_pkg::SP_INF};
		end
		if (e < 1) begin
			evo = evo | 5'h03;
			return {sg, 31'h0};
		end
		return {sg, e[7:0], sig[22:0]};
	endfunction

	// Denormal source seen by a value-producing operation
	function automatic logic dn(input fpfre_pkg::fpfre_op_e k, input logic [63:0] x);
		return k != fpfre_pkg::OP_MOVE && x[30:23] == 8'h00 && x[22:0] != 23'h0;
	endfunction

	task automatic wscr(input logic [31:0] v);
		scr_wr_i = 1'b1;
		scr_wdata_i = v;
		@(negedge clock_i);
		scr_wr_i = 1'b0;
		scr_m = (v & fpfre_pkg::FP_STATUS_CONTROL_WMASK) | (32'h1 << fpfre_pkg::DN_BIT);
		@(negedge clock_i);
	endtask

	// Enables rewritten while flags and cause are kept
	task automatic en(input logic [4:0] x);
		wscr({scr_m[31:12], x, scr_m[6:0]});
	endtask

	task automatic ld(input logic [3:0] i, input logic [63:0] d, input logic p);
		ld_valid_i = 1'b1;
		ld_idx_i = i;
		ld_data_i = d;
		@(negedge clock_i);
		ld_valid_i = 1'b0;
		regs_m[i] = p ? d[63:32] : d[31:0];
		if (p) begin
			regs_m[i+1] = d[31:0];
		end
	endtask

	task automatic rdck(input logic [3:0] i, input logic p);
		rd_idx_i = i;
		rd_pair_i = p;
		@(negedge clock_i);
		if (p) begin
			chk_val(rd_data_o, {regs_m[{i[3:1], 1'b0}], regs_m[{i[3:1], 1'b1}]});
		end else begin
			chk_val({32'h0, rd_data_o[31:0]}, {32'h0, regs_m[i]});
		end
	endtask

	// One issue; model updates cause, flags and destination, then compares all
	task automatic run(input fpfre_pkg::fpfre_op_e k, input logic [3:0] d, input logic [63:0] a,
		input logic [63:0] b, input logic sg, input int e, input logic [54:0] mm,
		input logic [4:0] fl, input logic [63:0] res, input logic [4:0] evx, input logic t,
		input logic dbl);
		logic [7:0] c0;
		c0 = cnt;
		op_valid_i = 1'b1;
		op_kind_i = k;
		op_dest_i = d;
		src_a_i = a;
		src_b_i = b;
		res_sign_i = sg;
		res_exp_i = e[13:0];
		res_mant_i = mm;
		{invalid_i, div_zero_i, may_ovf_i, may_unf_i, may_inx_i} = fl;
		#1;
		chk_ctl({30'h0, flush_a_o, flush_b_o}, {30'h0, dn(k, a), dn(k, b)});
		@(negedge clock_i);
		op_valid_i = 1'b0;
		repeat (2) @(negedge clock_i);
		scr_m[16:12] = evx;
		scr_m[6:2] = scr_m[6:2] | evx;
		if (!t) begin
			regs_m[d] = dbl ? res[63:32] : res[31:0];
			if (dbl) begin
				regs_m[d+1] = res[31:0];
			end
		end
		chk_ctl(scr_o, scr_m);
		chk_ctl({24'h0, cnt - c0}, {31'h0, t});
		rdck(d, dbl);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{op_valid_i, res_sign_i, res_zero_i, invalid_i, div_zero_i, may_ovf_i} = 6'h00;
		{may_unf_i, may_inx_i, ld_valid_i, rd_pair_i, scr_wr_i, xfer_wr_i} = 6'h00;
		op_kind_i = fpfre_pkg::OP_ARITH;
		{op_dest_i, ld_idx_i, rd_idx_i} = 12'h000;
		{src_a_i, src_b_i, ld_data_i} = '0;
		res_exp_i = 14'sh0000;
		res_mant_i = '0;
		{scr_wdata_i, xfer_wdata_i} = 64'h0;
		fails = 0;
		checked = 0;
		for (int i = 0; i < 16; i++) begin
			regs_m[i] = 32'h0;
		end
		void'($urandom(87));
		repeat (12) @(negedge clock_i);
		rst_i = 1'b0;
		chk_ctl(scr_o, fpfre_pkg::FP_STATUS_CONTROL_RESET);
		chk_ctl(xfer_o, 32'h0);
		rdck(4'h7, 1'b1);
		wscr(32'hffffffff);
		chk_ctl(scr_o, scr_m);
		w = $urandom;
		xfer_wr_i = 1'b1;
		xfer_wdata_i = w;
		@(negedge clock_i);
		xfer_wr_i = 1'b0;
		chk_ctl(xfer_o, w);
		// Paired load under the size bit, single load without it
		wscr(32'h1 << fpfre_pkg::SZ_BIT);
		ld(4'h2, {$urandom, $urandom}, 1'b1);
		wscr(32'h0);
		ld(4'h5, {32'h0, $urandom}, 1'b0);
		for (int i = 2; i < 6; i++) begin
			rdck(4'(i), 1'b0);
		end
		rdck(4'h2, 1'b1);
		// Rounding table; possible-event inputs set with every trap disabled
		for (int i = 0; i < 7; i++) begin
			m = mt[i];
			if (rmt[i] == 2'h1) begin
				m[29:0] = 30'($urandom);
			end
			s = 1'($urandom);
			wscr({scr_m[31:2], rmt[i]});
			r = sp_rnd(s, ext[i], m, rmt[i][0], ev);
			run(fpfre_pkg::OP_ARITH, 4'h1, 64'h3f800000, 64'h40000000, s, ext[i], m, 5'h07,
				{32'h0, r}, ev, 1'b0, 1'b0);
		end
		// NaN handling, divide by zero and traps
		en(5'h00);
		run(fpfre_pkg::OP_ARITH, 4'h6, 64'h7fc00000, 64'h3f800000, 1'b0, 127, mant_one, 5'h00,
			{32'h0, fpfre_pkg::SP_QUIET_NAN}, 5'h10, 1'b0, 1'b0);
		en(5'h10);
		run(fpfre_pkg::OP_ARITH, 4'h6, 64'h7fc00000, 64'h3f800000, 1'b0, 127, mant_one, 5'h00,
			64'h0, 5'h10, 1'b1, 1'b0);
		run(fpfre_pkg::OP_ARITH, 4'h6, 64'h7f800001, 64'h3f800000, 1'b0, 127, mant_one, 5'h00,
			{32'h0, fpfre_pkg::SP_QUIET_NAN}, 5'h00, 1'b0, 1'b0);
		run(fpfre_pkg::OP_MOVE, 4'h7, 64'h7fc00000, 64'h0, 1'b0, 127, mant_one, 5'h00,
			64'h7fc00000, 5'h00, 1'b0, 1'b0);
		en(5'h00);
		run(fpfre_pkg::OP_DIVIDE, 4'h9, 64'h3f800000, 64'h0, 1'b1, 127, mant_one, 5'h08,
			{32'h0, 1'b1, fpfre_pkg::SP_INF}, 5'h08, 1'b0, 1'b0);
		en(5'h08);
		run(fpfre_pkg::OP_DIVIDE, 4'h9, 64'h3f800000, 64'h0, 1'b1, 127, mant_one, 5'h08,
			64'h0, 5'h08, 1'b1, 1'b0);
		en(5'h01);
		run(fpfre_pkg::OP_ARITH, 4'h9, 64'h3f800000, 64'h3f800000, 1'b0, 127, mant_one, 5'h01,
			64'h0, 5'h00, 1'b1, 1'b0);
		en(5'h00);
		run(fpfre_pkg::OP_ARITH, 4'hb, 64'h1, 64'h3, 1'b0, 127, mant_one, 5'h00,
			64'h3f800000, 5'h00, 1'b0, 1'b0);
		run(fpfre_pkg::OP_MOVE, 4'hc, 64'h5, 64'h0, 1'b0, 127, mant_one, 5'h00,
			64'h5, 5'h00, 1'b0, 1'b0);
		// Double precision through the paired view
		wscr(scr_m | (32'h1 << fpfre_pkg::PR_BIT));
		f = 52'({$urandom, $urandom});
		run(fpfre_pkg::OP_ARITH, 4'h8, 64'h3ff0000000000000, 64'h3ff0000000000000, 1'b0, 1024,
			{1'b1, f, 2'b00}, 5'h00, {1'b0, 11'h400, f}, 5'h00, 1'b0, 1'b1);
		run(fpfre_pkg::OP_ARITH, 4'h8, 64'h7ff8000000000000, 64'h3ff0000000000000, 1'b0, 1024,
			mant_one, 5'h00, fpfre_pkg::DP_QUIET_NAN, 5'h10, 1'b0, 1'b1);
		summarize();
	end

	// Hang guard: an exhausted bound counts as a mismatch
	initial begin
		repeat (20000) @(posedge clock_i);
		fails = fails + 1;
		summarize();
	end
endmodule
